// file: hdl/pwr_mode_pkg.sv
// package: register map, field positions and timing for the power mode block
// assumes a 200 MHz system clock and an avalon-mm register bus
package pwr_mode_pkg;
    // =====================================================================
    // register map (byte addresses, one word each)
    localparam logic [3:0] power_mode_control_reg_off = 4'h0;
    localparam logic [3:0] watchdog_ctrl_off          = 4'h4;
    localparam logic [3:0] lost_clock_ctrl_off        = 4'h8;
    localparam logic [3:0] status_off                 = 4'hC;
    // =====================================================================
    // field positions
    localparam int idle_select_bit = 0;
    localparam int stop_select_bit = 1;
    localparam int wdt_enable_bit  = 0;
    localparam int wdt_lock_bit    = 1;
    localparam int wdt_kick_bit    = 2;
    localparam int lcd_enable_bit  = 0;
    localparam int st_idle_bit     = 0;
    localparam int st_stop_bit     = 1;
    localparam int st_wdt_rst_bit  = 2;
    localparam int st_lcd_rst_bit  = 3;
    localparam int st_pin_rst_bit  = 4;
    // =====================================================================
    // reset values
    localparam logic [1:0] power_mode_control_reg_reset = 2'h0;
    localparam logic       wdt_en_reset   = 1'b1;
    localparam logic       wdt_lock_reset = 1'b0;
    localparam logic       lcd_en_reset   = 1'b1;
    // =====================================================================
    // timing
    localparam int clk_mhz              = 200;
    localparam int lcd_timeout_us       = 100;
    localparam int lcd_timeout_cycles   = lcd_timeout_us * clk_mhz;
    localparam int wdt_timeout_cycles   = 1000000;
    localparam int reset_seq_cycles     = 16;
    localparam logic [15:0] reset_vector = 16'h0000;
    // =====================================================================
    // power states
    typedef enum logic [1:0] {
        st_run,
        st_idle,
        st_stop,
        st_reset
    } pwr_state_t;
endpackage

// file: hdl/pin_sync.sv
// three-stage synchroniser for an asynchronous pin
// assumes clk is the system clock; change counts when stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module pin_sync (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic pin_in,
    output var  logic level_out
);
    logic s1_q;
    logic s2_q;
    logic s3_q;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
        end else begin
            s1_q <= pin_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            level_out <= 1'b0;
        end else if (s2_q == s3_q) begin
            level_out <= s3_q;
        end
    end
endmodule
`default_nettype wire

// file: hdl/timeout_counter.sv
// up counter that raises a one-cycle expiry pulse
// assumes clear and run come from logic on the same clock
`timescale 1ns/1ps
`default_nettype none
module timeout_counter #(
    parameter int LIMIT = 16
) (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic clear,
    input  wire logic run,
    output var  logic expired
);
    logic [31:0] count_q;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            count_q <= 32'h0;
            expired <= 1'b0;
        end else if (clear || !run) begin
            count_q <= 32'h0;
            expired <= 1'b0;
        end else if (count_q == 32'(LIMIT - 1)) begin
            count_q <= 32'h0;
            expired <= 1'b1;
        end else begin
            count_q <= count_q + 32'h1;
            expired <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// file: hdl/pwr_mode_ctrl.sv
// power mode controller: idle and stop modes, watchdog and lost clock resets
// assumes the core pulses instr_done at each instruction end, and that
// analog peripherals are switched off by software before stop
//
// Summary of operation
// RULE_01: a write setting the idle select bit enters idle once the writing instruction completes.
// RULE_02: in idle the core is frozen so registers and memory hold while clocks and peripherals run.
// RULE_03: idle ends on an enabled pending interrupt or the external reset pin.
// RULE_04: an interrupt ending idle clears the idle select bit, resumes the core and lets it service the interrupt.
// RULE_05: after the interrupt return the core continues after the instruction that set idle.
// RULE_06: a reset ending idle runs the reset sequence and fetches from address zero.
// RULE_07: with the watchdog enabled it keeps counting in idle and its reset ends idle.
// RULE_08: software may disable the watchdog before idle only if it is not locked.
// RULE_09: a write setting the stop select bit enters stop once the writing instruction completes.
// RULE_10: stop halts the core and oscillators, gating peripherals and timers; only the lost clock detector runs.
// RULE_11: only a reset ends stop, followed by the reset sequence from address zero.
// RULE_12: with the lost clock detector enabled, its 100 us timeout raises a reset that ends stop.
// RULE_13: software should disable the lost clock detector before a stop longer than 100 us.
// RULE_14: software must switch off analog peripherals before setting the stop select bit.
// RULE_15: every reset clears both select bits so the core leaves reset in run mode.
//
// Local design decisions: the register offsets and the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
module pwr_mode_ctrl
    import pwr_mode_pkg::*;
#(
    parameter int WDT_CYCLES = pwr_mode_pkg::wdt_timeout_cycles,
    parameter int LCD_CYCLES = pwr_mode_pkg::lcd_timeout_cycles
) (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        reset_pin_n,
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output var  logic [31:0] avs_readdata,
    output var  logic        avs_waitrequest,
    input  wire logic        instr_done,
    input  wire logic        irq_pending,
    output var  logic        core_halt,
    output var  logic        osc_enable,
    output var  logic        periph_clk_enable,
    output var  logic        core_reset,
    output var  logic [15:0] fetch_vector,
    output var  logic        irq_wake
);
    import pwr_mode_pkg::*;

    // =====================================================================
    // state
    pwr_state_t  state_q;
    logic [1:0]  power_mode_control_reg_q;
    logic [1:0]  pending_q;
    logic        wdt_en_q;
    logic        wdt_lock_q;
    logic        lcd_en_q;
    logic        wdt_rst_seen_q;
    logic        lcd_rst_seen_q;
    logic        pin_rst_seen_q;
    logic [4:0]  seq_q;
    logic        ack_q;
    logic        pin_level;
    logic        pin_rst;
    logic        wdt_expired;
    logic        lcd_expired;
    logic        wdt_kick;
    logic        bus_access;
    logic        wr_power_mode_control_reg;
    logic        wr_take;
    logic        wr_wdt;
    logic        wr_lcd;
    logic        wr_status;
    logic        any_rst;

    pin_sync u_pin_sync (
        .clk       (clk),
        .rst       (rst),
        .pin_in    (!reset_pin_n),
        .level_out (pin_level)
    );

    // pin synchronised as asserted-high, so a reset never fakes a pin cause
    assign pin_rst = pin_level;

    assign bus_access = (avs_read || avs_write) && !ack_q;
    // writes commit on the edge that samples waitrequest low
    assign wr_take    = avs_write && ack_q && avs_byteenable[0];
    assign wdt_kick   = wr_wdt && avs_writedata[wdt_kick_bit];

    always_comb begin
        wr_power_mode_control_reg   = 1'b0;
        wr_wdt    = 1'b0;
        wr_lcd    = 1'b0;
        wr_status = 1'b0;
        if (wr_take) begin
            if (avs_address == power_mode_control_reg_off) begin
                wr_power_mode_control_reg = 1'b1;
            end else if (avs_address == watchdog_ctrl_off) begin
                wr_wdt = 1'b1;
            end else if (avs_address == lost_clock_ctrl_off) begin
                wr_lcd = 1'b1;
            end else if (avs_address == status_off) begin
                wr_status = 1'b1;
            end
        end
    end

    // watchdog counts in run and idle; stop holds its count cleared at zero
    timeout_counter #(
        .LIMIT (WDT_CYCLES)
    ) u_wdt (
        .clk     (clk),
        .rst     (rst),
        .clear   (wdt_kick || core_reset),
        .run     (wdt_en_q && (state_q != st_stop)), // [RULE_07]
        .expired (wdt_expired)
    );

    // lost clock detector is the only counter alive in stop
    timeout_counter #(
        .LIMIT (LCD_CYCLES)
    ) u_lcd (
        .clk     (clk),
        .rst     (rst),
        .clear   (core_reset),
        .run     (lcd_en_q && (state_q == st_stop)), // [RULE_10] [RULE_12]
        .expired (lcd_expired)
    );

    assign any_rst = pin_rst || wdt_expired || lcd_expired;

    // =====================================================================
    // avalon-mm slave: one wait cycle, then ack
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= bus_access;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            avs_waitrequest <= 1'b1;
        end else begin
            avs_waitrequest <= !bus_access;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            avs_readdata <= 32'h0;
        end else if (avs_read && !ack_q) begin
            if (avs_address == power_mode_control_reg_off) begin
                avs_readdata <= {30'h0, power_mode_control_reg_q | pending_q};
            end else if (avs_address == watchdog_ctrl_off) begin
                avs_readdata <= {30'h0, wdt_lock_q, wdt_en_q};
            end else if (avs_address == lost_clock_ctrl_off) begin
                avs_readdata <= {31'h0, lcd_en_q};
            end else if (avs_address == status_off) begin
                avs_readdata <= {27'h0, pin_rst_seen_q, lcd_rst_seen_q,
                                 wdt_rst_seen_q,
                                 state_q == st_stop, state_q == st_idle};
            end else begin
                avs_readdata <= 32'h0;
            end
        end
    end

    // =====================================================================
    // control registers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wdt_en_q   <= wdt_en_reset;
            wdt_lock_q <= wdt_lock_reset;
        end else if (core_reset) begin
            wdt_en_q   <= wdt_en_reset;
            wdt_lock_q <= wdt_lock_reset;
        end else if (wr_wdt) begin
            // disable honoured only while unlocked; lock is sticky
            if (!wdt_lock_q) begin
                wdt_en_q <= avs_writedata[wdt_enable_bit]; // [RULE_08]
            end
            if (avs_writedata[wdt_lock_bit]) begin
                wdt_lock_q <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            lcd_en_q <= lcd_en_reset;
        end else if (core_reset) begin
            lcd_en_q <= lcd_en_reset;
        end else if (wr_lcd) begin
            lcd_en_q <= avs_writedata[lcd_enable_bit]; // [RULE_13]
        end
    end

    // reset cause flags: set wins over a clearing write
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wdt_rst_seen_q <= 1'b0;
            lcd_rst_seen_q <= 1'b0;
            pin_rst_seen_q <= 1'b0;
        end else begin
            if (wdt_expired) begin
                wdt_rst_seen_q <= 1'b1;
            end else if (wr_status && avs_writedata[st_wdt_rst_bit]) begin
                wdt_rst_seen_q <= 1'b0;
            end
            if (lcd_expired) begin
                lcd_rst_seen_q <= 1'b1;
            end else if (wr_status && avs_writedata[st_lcd_rst_bit]) begin
                lcd_rst_seen_q <= 1'b0;
            end
            if (pin_rst) begin
                pin_rst_seen_q <= 1'b1;
            end else if (wr_status && avs_writedata[st_pin_rst_bit]) begin
                pin_rst_seen_q <= 1'b0;
            end
        end
    end

    // =====================================================================
    // mode select bits, armed until the writing instruction completes
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pending_q <= power_mode_control_reg_reset;
        end else if (any_rst || core_reset) begin
            pending_q <= power_mode_control_reg_reset; // [RULE_15]
        end else if (wr_power_mode_control_reg) begin
            pending_q <= pending_q | avs_writedata[1:0];
        end else if (instr_done) begin
            pending_q <= power_mode_control_reg_reset;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            power_mode_control_reg_q <= power_mode_control_reg_reset;
        end else if (any_rst || core_reset) begin
            power_mode_control_reg_q <= power_mode_control_reg_reset; // [RULE_15] [RULE_06] [RULE_11]
        end else if (state_q == st_idle && irq_pending) begin
            power_mode_control_reg_q[idle_select_bit] <= 1'b0; // [RULE_04]
        end else if (state_q == st_run && instr_done) begin
            power_mode_control_reg_q <= pending_q; // [RULE_01] [RULE_09]
        end
    end

    // =====================================================================
    // power state machine
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q <= st_reset;
        end else begin
            case (state_q)
                st_run: begin
                    if (any_rst) begin
                        state_q <= st_reset;
                    end else if (instr_done
                                 && pending_q[stop_select_bit]) begin
                        state_q <= st_stop; // [RULE_09]
                    end else if (instr_done
                                 && pending_q[idle_select_bit]) begin
                        state_q <= st_idle; // [RULE_01]
                    end
                end
                st_idle: begin
                    if (any_rst) begin
                        state_q <= st_reset; // [RULE_03] [RULE_06] [RULE_07]
                    end else if (irq_pending) begin
                        state_q <= st_run; // [RULE_03] [RULE_04]
                    end
                end
                st_stop: begin
                    // interrupts ignored; only a reset wakes the core
                    if (any_rst) begin
                        state_q <= st_reset; // [RULE_11] [RULE_12]
                    end
                end
                st_reset: begin
                    if (!pin_rst && seq_q == 5'(reset_seq_cycles - 1)) begin
                        state_q <= st_run;
                    end
                end
                default: begin
                    state_q <= st_reset;
                end
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            seq_q <= 5'h0;
        end else if (state_q != st_reset || pin_rst) begin
            seq_q <= 5'h0;
        end else if (seq_q != 5'(reset_seq_cycles - 1)) begin
            seq_q <= seq_q + 5'h1;
        end
    end

    // =====================================================================
    // outputs to the core and clock tree
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            core_halt  <= 1'b1;
            core_reset <= 1'b1;
        end else begin
            // halt freezes the core so its state holds across idle
            core_halt  <= (state_q != st_run) || any_rst; // [RULE_02]
            core_reset <= (state_q == st_reset) || any_rst; // [RULE_06]
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            osc_enable        <= 1'b1;
            periph_clk_enable <= 1'b0;
        end else begin
            osc_enable        <= (state_q != st_stop); // [RULE_10]
            periph_clk_enable <= (state_q == st_run)
                                 || (state_q == st_idle); // [RULE_02]
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            fetch_vector <= reset_vector;
        end else begin
            fetch_vector <= reset_vector; // [RULE_11]
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irq_wake <= 1'b0;
        end else begin
            // pc untouched on wake, so return lands after the idle write
            irq_wake <= (state_q == st_idle) && irq_pending
                        && !any_rst; // [RULE_05]
        end
    end
endmodule
`default_nettype wire

// file: test/pwr_mode_ctrl_asserts.sv
// checker: mode relations seen at the power mode controller ports
// assumes it is bound onto pwr_mode_ctrl, one clock domain
`timescale 1ns/1ps
`default_nettype none
module pwr_mode_ctrl_chk (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        instr_done,
    input wire logic        irq_pending,
    input wire logic        core_halt,
    input wire logic        osc_enable,
    input wire logic        periph_clk_enable,
    input wire logic        core_reset,
    input wire logic [15:0] fetch_vector,
    input wire logic        irq_wake
);
    // ==========================================================
    // mode relations
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    chk_reset_halts: assert property (core_reset |-> core_halt)
        else $error("core running during reset");
    chk_stop_gates: assert property (
        !osc_enable |-> core_halt && !periph_clk_enable)
        else $error("stop without core and peripheral halt");
    chk_idle_clocks: assert property (
        core_halt && !core_reset && osc_enable |-> periph_clk_enable)
        else $error("peripheral clock lost in idle");
    chk_wake_single: assert property (irq_wake |=> !irq_wake)
        else $error("wake pulse longer than one cycle");
    chk_wake_cause: assert property (
        irq_wake |-> $past(irq_pending))
        else $error("wake without pending interrupt");
    chk_wake_resume: assert property (
        irq_wake |-> ##[0:1] !core_halt)
        else $error("core not resumed after wake");
    chk_stop_exit: assert property (
        $rose(osc_enable) |-> core_reset)
        else $error("stop left without reset");
    chk_stop_no_wake: assert property (
        !osc_enable |-> !irq_wake)
        else $error("interrupt wake during stop");
    chk_vector_zero: assert property (
        $fell(core_reset) |-> fetch_vector == 16'h0000)
        else $error("fetch vector not zero");
    chk_halt_cause: assert property (
        $rose(core_halt) && !core_reset
        |-> $past(instr_done) || $past(instr_done, 2))
        else $error("halt without instruction end");
    chk_run_after: assert property (
        $fell(core_reset) |-> osc_enable && periph_clk_enable)
        else $error("reset not leaving run mode");
endmodule
bind pwr_mode_ctrl pwr_mode_ctrl_chk u_chk (.clk(clk), .rst(rst),
    .instr_done(instr_done), .irq_pending(irq_pending),
    .core_halt(core_halt), .osc_enable(osc_enable),
    .periph_clk_enable(periph_clk_enable), .core_reset(core_reset),
    .fetch_vector(fetch_vector), .irq_wake(irq_wake));
`default_nettype wire

// file: test/cpu_idle_stop_power_modes_test.sv
// testbench: idle, stop, watchdog and lost clock scenarios over avalon
// assumes shortened timeouts: watchdog 200 cycles, lost clock 30 cycles
`timescale 1ns/1ps
`default_nettype none
module cpu_idle_stop_power_modes_test;
    import pwr_mode_pkg::*;
    logic        clk, rst, reset_pin_n, avs_read, avs_write;
    logic [3:0]  avs_address, avs_byteenable;
    logic [31:0] avs_writedata, avs_readdata;
    logic        avs_waitrequest, instr_done, irq_pending, core_halt;
    logic        osc_enable, periph_clk_enable, core_reset, irq_wake;
    logic [15:0] fetch_vector;
    int          failures, checks_done, cycles;
    pwr_mode_ctrl #(.WDT_CYCLES(200), .LCD_CYCLES(30)) dut (.clk(clk),
        .rst(rst), .reset_pin_n(reset_pin_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .instr_done(instr_done), .irq_pending(irq_pending),
        .core_halt(core_halt), .osc_enable(osc_enable),
        .periph_clk_enable(periph_clk_enable), .core_reset(core_reset),
        .fetch_vector(fetch_vector), .irq_wake(irq_wake));
    // ==========================================================
    // clock and timeout
    initial begin
        clk = 1'h0;
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 6000) begin
            failures++;
            finish_test();
        end
    end
    // ==========================================================
    // helpers
    task automatic finish_test();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    function automatic logic sel(input int s);
        case (s)
            0: return core_halt;
            1: return core_reset;
            2: return osc_enable;
            3: return periph_clk_enable;
            default: return irq_wake;
        endcase
    endfunction
    // wait up to lim edges for an output level, then compare it
    task automatic wait_on(input int s, input logic v, input int lim);
        int n = 0;
        while (sel(s) !== v && n < lim) begin
            @(posedge clk);
            n++;
        end
        check({31'h0, sel(s)}, {31'h0, v});
    endtask
    task automatic bus(input logic [3:0] a, input logic w,
                       input logic [31:0] wd, output logic [31:0] rd);
        avs_address   <= a;
        avs_write     <= w;
        avs_read      <= !w;
        avs_writedata <= wd;
        do begin
            @(posedge clk);
        end while (avs_waitrequest !== 1'h0);
        rd = avs_readdata;
        avs_read  <= 1'h0;
        avs_write <= 1'h0;
        @(posedge clk);
        check({31'h0, avs_waitrequest}, 32'h1);
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        logic [31:0] v;
        bus(a, 1'h1, d, v);
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] e,
                      input logic [31:0] m);
        logic [31:0] v;
        bus(a, 1'h0, 32'h0, v);
        check(v & m, e);
    endtask
    task automatic step();
        instr_done <= 1'h1;
        @(posedge clk);
        instr_done <= 1'h0;
    endtask
    task automatic do_reset();
        rst <= 1'h1;
        repeat (6) @(posedge clk);
        rst <= 1'h0;
        wait_on(1, 1'h0, 60);
        repeat (2) @(posedge clk);
        wait_on(0, 1'h0, 0);
        wait_on(3, 1'h1, 0);
    endtask
    // ==========================================================
    // scenarios
    initial begin
        {rst, reset_pin_n, avs_byteenable} = 6'h3F;
        {avs_read, avs_write, instr_done, irq_pending} = 4'h0;
        {avs_address, avs_writedata} = 36'h0;
        {failures, checks_done, cycles} = 0;
        do_reset();
        rd(power_mode_control_reg_off, 32'h0, 32'h3);
        rd(watchdog_ctrl_off, 32'h1, 32'h3);
        rd(lost_clock_ctrl_off, 32'h1, 32'h1);
        rd(status_off, 32'h0, 32'h1F);
        rd(4'h6, 32'h0, 32'hFFFFFFFF);
        $display("test reset values done");
        wr(watchdog_ctrl_off, 32'h0);
        wr(power_mode_control_reg_off, 32'h1);
        repeat (5) @(posedge clk);
        wait_on(0, 1'h0, 0);
        step();
        wait_on(0, 1'h1, 4);
        rd(status_off, 32'h1, 32'h1);
        repeat (250) @(posedge clk);
        wait_on(1, 1'h0, 0);
        wait_on(0, 1'h1, 0);
        irq_pending <= 1'h1;
        wait_on(4, 1'h1, 8);
        irq_pending <= 1'h0;
        repeat (2) @(posedge clk);
        wait_on(0, 1'h0, 0);
        rd(power_mode_control_reg_off, 32'h0, 32'h3);
        $display("test idle wake done");
        do_reset();
        wr(watchdog_ctrl_off, 32'h7);
        wr(watchdog_ctrl_off, 32'h0);
        rd(watchdog_ctrl_off, 32'h3, 32'h3);
        wr(power_mode_control_reg_off, 32'h1);
        step();
        wait_on(0, 1'h1, 4);
        wait_on(1, 1'h1, 260);
        wait_on(1, 1'h0, 60);
        check({16'h0, fetch_vector}, 32'h0);
        rd(status_off, 32'h4, 32'h4);
        rd(power_mode_control_reg_off, 32'h0, 32'h3);
        $display("test watchdog in idle done");
        do_reset();
        wr(watchdog_ctrl_off, 32'h0);
        wr(power_mode_control_reg_off, 32'h2);
        wait_on(2, 1'h1, 0);
        step();
        wait_on(2, 1'h0, 4);
        wait_on(3, 1'h0, 0);
        irq_pending <= 1'h1;
        repeat (5) @(posedge clk);
        wait_on(2, 1'h0, 0);
        irq_pending <= 1'h0;
        wait_on(1, 1'h1, 60);
        wait_on(1, 1'h0, 60);
        rd(status_off, 32'h8, 32'h8);
        rd(power_mode_control_reg_off, 32'h0, 32'h3);
        $display("test stop lost clock done");
        do_reset();
        wr(watchdog_ctrl_off, 32'h0);
        wr(lost_clock_ctrl_off, 32'h0);
        wr(power_mode_control_reg_off, 32'h2);
        step();
        wait_on(2, 1'h0, 4);
        repeat (90) @(posedge clk);
        wait_on(2, 1'h0, 0);
        reset_pin_n <= 1'h0;
        wait_on(1, 1'h1, 10);
        repeat (2) @(posedge clk);
        reset_pin_n <= 1'h1;
        wait_on(1, 1'h0, 60);
        rd(status_off, 32'h10, 32'h10);
        wr(status_off, 32'h1C);
        rd(status_off, 32'h0, 32'h1C);
        rd(power_mode_control_reg_off, 32'h0, 32'h3);
        $display("test stop pin wake done");
        finish_test();
    end
endmodule
`default_nettype wire
